//--- src/crs_irq_latch.sv
// Pending interrupt latches, one per enable flag.
// Assumes requests are synchronous to clk_sys.
module crs_irq_latch (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [3:0] req,
  input wire logic [3:0] enable,
  input wire logic [3:0] taken,
  output logic [3:0] pending
);
  logic [3:0] pend_r;
  logic [3:0] pend_nxt;

  always_comb begin
    pend_nxt = pend_r;
    for (int i = 0; i < crs_pkg::NUM_SRC; i++) begin
      if (taken[i]) begin
        pend_nxt[i] = 1'b0;
      end
      if (req[i] && enable[i]) begin
        pend_nxt[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pend_r <= 4'h0;
    end else begin
      pend_r <= pend_nxt;
    end
  end

  assign pending = pend_r;
endmodule // crs_irq_latch

//--- src/crs_pkg.sv
// Package for the CPU register and stack block.
// Assumes a single 40 MHz clock and an APB register slave.
package crs_pkg;
  localparam logic [15:0] SP_UPPER = 16'h00FF;
  localparam logic [15:0] SP_LOWER = 16'h00C0;
  localparam logic [9:0] SP_FIXED_HI = 10'h003;
  localparam logic [5:0] SP_RESET_LOW = 6'h3F;
  localparam int PC_LIVE_BITS = 14;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [2:0] CALL_BYTES = 3'h2;
  localparam logic [2:0] IRQ_BYTES = 3'h5;
  // APB byte offsets
  localparam logic [7:0] OFS_ACC = 8'h00;
  localparam logic [7:0] OFS_IDX1 = 8'h04;
  localparam logic [7:0] OFS_IDX2 = 8'h08;
  localparam logic [7:0] OFS_PC = 8'h0C;
  localparam logic [7:0] OFS_SP = 8'h10;
  localparam logic [7:0] OFS_CTRL = 8'h14;
  localparam logic [7:0] OFS_STAT = 8'h18;
  localparam logic [7:0] OFS_IRQ = 8'h1C;
  // Control register bit positions
  localparam int CTRL_PUSH = 0;
  localparam int CTRL_POP = 1;
  localparam int CTRL_RSP = 2;
  localparam int CTRL_CALL = 3;
  localparam int CTRL_IRQ = 4;
  localparam int CTRL_IRET = 5;
  localparam int CTRL_PREFIX = 6;
  localparam int CTRL_MASK = 7;
  localparam int NUM_SRC = 4;
  typedef enum logic [1:0] {OP_NONE, OP_PUSH, OP_POP} crs_op_type;
endpackage : crs_pkg

//--- src/crs_regs.sv
// CPU register file and stack control with an APB register port.
// Assumes the sequencer issues one operation at a time via control.
//
// Decided for this implementation: register access over APB and the placing of the registers.
module crs_regs (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] irq_req,
  output logic stack_we,
  output logic [15:0] stack_addr,
  output logic [7:0] stack_wdata,
  input wire logic [7:0] stack_rdata,
  output logic [7:0] index_operand,
  output logic busy,
  output logic irq_pending
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_PUSH, ST_POP
  } crs_state_type;

  crs_state_type state_r, state_nxt;
  logic [7:0] acc_r, acc_nxt;
  logic [7:0] idx1_r, idx1_nxt;
  logic [7:0] idx2_r, idx2_nxt;
  logic [13:0] pc_r, pc_nxt;
  logic [7:0] cc_r, cc_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic [2:0] total_r, total_nxt;
  logic prefix_r, prefix_nxt;
  logic mask_r, mask_nxt;
  logic [3:0] ien_r, ien_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pslverr_r, pslverr_nxt;
  logic reinit;
  logic [3:0] taken;
  logic [3:0] pending;
  logic [15:0] sp;
  logic [15:0] pc_full;
  crs_pkg::crs_op_type sp_op;
  logic wr_en;
  logic setup;
  logic [31:0] rd_word;
  logic [7:0] push_byte;

  assign pc_full = {2'b00, pc_r};
  assign wr_en = psel && penable && pwrite;
  assign setup = psel && !penable;
  assign pready = 1'b1;
  assign prdata = prdata_r;
  assign pslverr = pslverr_r;

  crs_stack_ptr u_sp (
    .clk_sys(clk_sys),
    .rst(rst),
    .reinit(reinit),
    .op(sp_op),
    .sp(sp)
  );

  crs_irq_latch u_irq (
    .clk_sys(clk_sys),
    .rst(rst),
    .req(irq_req),
    .enable(ien_r),
    .taken(taken),
    .pending(pending)
  );

  // Context order: pc low, pc high, idx1, acc, cc
  always_comb begin
    unique case (cnt_r)
      3'h0: push_byte = pc_full[7:0];
      3'h1: push_byte = pc_full[15:8];
      3'h2: push_byte = idx1_r;
      3'h3: push_byte = acc_r;
      default: push_byte = cc_r;
    endcase
  end

  always_comb begin
    state_nxt = state_r;
    acc_nxt = acc_r;
    idx1_nxt = idx1_r;
    idx2_nxt = idx2_r;
    pc_nxt = pc_r;
    cc_nxt = cc_r;
    cnt_nxt = cnt_r;
    total_nxt = total_r;
    prefix_nxt = prefix_r;
    mask_nxt = mask_r;
    ien_nxt = ien_r;
    rd_word = 32'h0000_0000;
    pslverr_nxt = 1'b0;
    prdata_nxt = prdata_r;
    reinit = 1'b0;
    sp_op = crs_pkg::OP_NONE;
    taken = 4'h0;
    stack_we = 1'b0;
    stack_wdata = push_byte;
    unique case (state_r)
      ST_IDLE: begin
        if (wr_en) begin
          unique case (paddr)
            crs_pkg::OFS_ACC: acc_nxt = pwdata[7:0];
            crs_pkg::OFS_IDX1: idx1_nxt = pwdata[7:0];
            crs_pkg::OFS_IDX2: idx2_nxt = pwdata[7:0];
            crs_pkg::OFS_PC: pc_nxt = pwdata[13:0];
            crs_pkg::OFS_IRQ: ien_nxt = pwdata[3:0];
            crs_pkg::OFS_CTRL: begin
              prefix_nxt = pwdata[crs_pkg::CTRL_PREFIX];
              mask_nxt = pwdata[crs_pkg::CTRL_MASK];
              if (pwdata[crs_pkg::CTRL_RSP]) begin
                reinit = 1'b1;
              end else if (pwdata[crs_pkg::CTRL_PUSH]) begin
                stack_we = 1'b1;
                stack_wdata = acc_r;
                sp_op = crs_pkg::OP_PUSH;
              end else if (pwdata[crs_pkg::CTRL_POP]) begin
                state_nxt = ST_POP;
                cnt_nxt = 3'h0;
                total_nxt = 3'h1;
              end else if (pwdata[crs_pkg::CTRL_CALL]) begin
                state_nxt = ST_PUSH;
                cnt_nxt = 3'h0;
                total_nxt = crs_pkg::CALL_BYTES;
              end else if (pwdata[crs_pkg::CTRL_IRQ]) begin
                state_nxt = ST_PUSH;
                cnt_nxt = 3'h0;
                total_nxt = crs_pkg::IRQ_BYTES;
                mask_nxt = 1'b1;
              end else if (pwdata[crs_pkg::CTRL_IRET]) begin
                state_nxt = ST_POP;
                cnt_nxt = crs_pkg::IRQ_BYTES;
                total_nxt = crs_pkg::IRQ_BYTES;
              end
            end
            default: begin
            end
          endcase
        end else if (!mask_r && pending != 4'h0) begin
          // Pending request taken: lowest index first
          for (int i = crs_pkg::NUM_SRC - 1; i >= 0; i--) begin
            if (pending[i]) begin
              taken = 4'h0;
              taken[i] = 1'b1;
            end
          end
          state_nxt = ST_PUSH;
          cnt_nxt = 3'h0;
          total_nxt = crs_pkg::IRQ_BYTES;
          mask_nxt = 1'b1;
        end
      end
      ST_PUSH: begin
        stack_we = 1'b1;
        sp_op = crs_pkg::OP_PUSH;
        cnt_nxt = cnt_r + 3'h1;
        if (cnt_r + 3'h1 == total_r) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_POP: begin
        // Pre-increment then read; data is captured in the same cycle
        sp_op = crs_pkg::OP_POP;
        state_nxt = ST_IDLE;
        if (total_r == 3'h1) begin
          acc_nxt = stack_rdata;
        end else begin
          cnt_nxt = cnt_r - 3'h1;
          unique case (cnt_r)
            3'h5: cc_nxt = stack_rdata;
            3'h4: acc_nxt = stack_rdata;
            3'h3: idx1_nxt = stack_rdata;
            3'h2: pc_nxt[13:8] = stack_rdata[5:0];
            default: pc_nxt[7:0] = stack_rdata;
          endcase
          if (cnt_r != 3'h1) begin
            state_nxt = ST_POP;
          end else begin
            mask_nxt = 1'b0;
          end
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
    // Decoded at setup so data and error stand at the access edge
    unique case (paddr)
      crs_pkg::OFS_ACC: rd_word = {24'h0, acc_r};
      crs_pkg::OFS_IDX1: rd_word = {24'h0, idx1_r};
      crs_pkg::OFS_IDX2: rd_word = {24'h0, idx2_r};
      crs_pkg::OFS_PC: rd_word = {16'h0, pc_full};
      crs_pkg::OFS_SP: rd_word = {16'h0, sp};
      crs_pkg::OFS_CTRL: rd_word = {24'h0, mask_r, prefix_r, 6'h00};
      crs_pkg::OFS_STAT: rd_word = {24'h0, pending, 1'b0, busy, 2'b00};
      crs_pkg::OFS_IRQ: rd_word = {28'h0, ien_r};
      default: pslverr_nxt = setup;
    endcase
    if (setup && !pwrite) begin
      prdata_nxt = rd_word;
    end
  end

  // Pop address is the slot above the current free location
  assign stack_addr = (state_r == ST_POP) ?
    {crs_pkg::SP_FIXED_HI, sp[5:0] + 6'h01} : sp;
  assign busy = (state_r != ST_IDLE);
  assign irq_pending = |pending;
  assign index_operand = prefix_r ? idx2_r : idx1_r;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
      acc_r <= crs_pkg::REG_RESET;
      idx1_r <= crs_pkg::REG_RESET;
      idx2_r <= crs_pkg::REG_RESET;
      pc_r <= crs_pkg::PC_RESET[13:0];
      cc_r <= crs_pkg::REG_RESET;
      cnt_r <= 3'h0;
      total_r <= 3'h0;
      prefix_r <= 1'b0;
      mask_r <= 1'b1;
      ien_r <= 4'h0;
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      acc_r <= acc_nxt;
      idx1_r <= idx1_nxt;
      idx2_r <= idx2_nxt;
      pc_r <= pc_nxt;
      cc_r <= cc_nxt;
      cnt_r <= cnt_nxt;
      total_r <= total_nxt;
      prefix_r <= prefix_nxt;
      mask_r <= mask_nxt;
      ien_r <= ien_nxt;
      prdata_r <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end
endmodule // crs_regs

//--- src/crs_stack_ptr.sv
// Stack pointer with six live bits.
// Assumes one push or pop request per cycle at most.
module crs_stack_ptr (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic reinit,
  input wire crs_pkg::crs_op_type op,
  output logic [15:0] sp
);
  logic [5:0] low_r;
  logic [5:0] low_nxt;

  always_comb begin
    low_nxt = low_r;
    if (reinit) begin
      low_nxt = crs_pkg::SP_RESET_LOW;
    end else if (op == crs_pkg::OP_PUSH) begin
      low_nxt = low_r - 6'h01;
    end else if (op == crs_pkg::OP_POP) begin
      low_nxt = low_r + 6'h01;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      low_r <= crs_pkg::SP_RESET_LOW;
    end else begin
      low_r <= low_nxt;
    end
  end

  assign sp = {crs_pkg::SP_FIXED_HI, low_r};
endmodule // crs_stack_ptr

//--- tb/crs_regs_assertions.sv
// Port checker for crs_regs.
// Bound to crs_regs; one clock domain.
module crs_regs_assertions (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] irq_req,
  input wire logic stack_we,
  input wire logic [15:0] stack_addr,
  input wire logic busy,
  input wire logic irq_pending
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic cw;
  assign cw = psel && penable && pwrite && !busy
    && paddr == crs_pkg::OFS_CTRL;
  chk_stack_range: assert property (
    stack_we |-> stack_addr[15:6] == crs_pkg::SP_FIXED_HI)
    else $error("stack write out of range");
  chk_push_step: assert property (
    stack_we ##1 stack_we
    |-> stack_addr[5:0] == $past(stack_addr[5:0]) - 6'h1)
    else $error("push step wrong");
  chk_push_one: assert property (
    cw && pwdata[2:0] == 3'h1 |-> stack_we ##1 !stack_we)
    else $error("push not one byte");
  chk_pop_none: assert property (
    cw && pwdata[2:0] == 3'h2 |-> ##1 !stack_we ##1 !stack_we)
    else $error("pop wrote stack");
  chk_call_two: assert property (
    cw && pwdata[4:0] == 5'h08 |-> ##1 stack_we [*2] ##1 !stack_we)
    else $error("call not two bytes");
  chk_irq_five: assert property (
    cw && pwdata[4:0] == 5'h10 |-> ##1 stack_we [*5] ##1 !stack_we)
    else $error("entry not five bytes");
  chk_busy_ends: assert property (
    $rose(busy) |-> ##[1:8] !busy)
    else $error("busy too long");
  chk_pend_cause: assert property (
    $rose(irq_pending) |-> $past(|irq_req))
    else $error("pending without request");
endmodule // crs_regs_assertions
bind crs_regs crs_regs_assertions u_chk (.clk_sys, .rst, .psel,
  .penable, .pwrite, .paddr, .pwdata, .irq_req, .stack_we,
  .stack_addr, .busy, .irq_pending);

//--- tb/crs_stack_ram.sv
// Stack RAM model on the far side of crs_regs.
// Assumes a combinational read of the addressed byte.
module crs_stack_ram (
  input wire logic clk_sys,
  input wire logic stack_we,
  input wire logic [15:0] stack_addr,
  input wire logic [7:0] stack_wdata,
  output logic [7:0] stack_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [64];
  always_ff @(posedge clk_sys) begin
    if (stack_we) begin
      mem[stack_addr[5:0]] <= stack_wdata;
    end
  end
  assign stack_rdata = mem[stack_addr[5:0]];
endmodule // crs_stack_ram

//--- tb/test_cpu_register_stack_control.sv
// Bench for crs_regs with a stack RAM model.
// Assumes crs_pkg, crs_regs and the RAM model compiled first.
module test_cpu_register_stack_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] irq_req = 4'h0;
  logic [31:0] prdata, r;
  logic pready, pslverr, stack_we, busy, irq_pending, err;
  logic [15:0] stack_addr;
  logic [7:0] stack_wdata, stack_rdata, index_operand;
  int mismatches = 0;
  int samples_checked = 0;
  always #12.5 clk_sys = ~clk_sys;
  crs_regs dut_u (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .irq_req, .stack_we,
    .stack_addr, .stack_wdata, .stack_rdata, .index_operand, .busy,
    .irq_pending);
  crs_stack_ram ram_u (.clk_sys, .stack_we, .stack_addr,
    .stack_wdata, .stack_rdata);
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e, string n);
    apb(1'b0, a, 32'h0);
    chk(n, e, r);
  endtask
  task automatic ctl(logic [7:0] d);
    apb(1'b1, 8'h14, {24'h0, d});
    r = 32'h4;
    for (int i = 0; i < 20 && r[2]; i++) apb(1'b0, 8'h18, 32'h0);
    chk("busy", 32'h0, r & 32'h4);
  endtask
  task automatic t_regs();
    rd(8'h10, 32'hFF, "sp");
    apb(1'b1, 8'h00, 32'hA5);
    apb(1'b1, 8'h04, 32'h3C);
    apb(1'b1, 8'h08, 32'hC3);
    apb(1'b1, 8'h0C, 32'hFFFF);
    rd(8'h00, 32'hA5, "acc");
    rd(8'h04, 32'h3C, "idx1");
    rd(8'h08, 32'hC3, "idx2");
    rd(8'h0C, 32'h3FFF, "pc");
    chk("opnd", 32'h3C, {24'h0, index_operand});
    ctl(8'hC0);
    chk("opnd", 32'hC3, {24'h0, index_operand});
    ctl(8'h80);
    apb(1'b0, 8'h20, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    $display("done regs");
  endtask
  task automatic t_stack();
    apb(1'b1, 8'h00, 32'h5A);
    ctl(8'h81);
    rd(8'h10, 32'hFE, "sp push");
    chk("ram", 32'h5A, {24'h0, ram_u.mem[63]});
    apb(1'b1, 8'h00, 32'h0);
    ctl(8'h82);
    rd(8'h10, 32'hFF, "sp pop");
    rd(8'h00, 32'h5A, "acc pop");
    for (int i = 0; i < 63; i++) ctl(8'h81);
    rd(8'h10, 32'hC0, "sp low");
    ctl(8'h81);
    rd(8'h10, 32'hFF, "sp wrap");
    ctl(8'h81);
    ctl(8'h84);
    rd(8'h10, 32'hFF, "sp rsp");
    $display("done stack");
  endtask
  task automatic t_irq();
    ctl(8'h88);
    rd(8'h10, 32'hFD, "sp call");
    ctl(8'h84);
    apb(1'b1, 8'h00, 32'h11);
    apb(1'b1, 8'h04, 32'h22);
    apb(1'b1, 8'h0C, 32'h1234);
    ctl(8'h90);
    rd(8'h10, 32'hFA, "sp irq");
    chk("pc lo", 32'h34, {24'h0, ram_u.mem[63]});
    chk("pc hi", 32'h12, {24'h0, ram_u.mem[62]});
    chk("idx1", 32'h22, {24'h0, ram_u.mem[61]});
    chk("acc", 32'h11, {24'h0, ram_u.mem[60]});
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b1, 8'h04, 32'h0);
    apb(1'b1, 8'h08, 32'h44);
    ctl(8'h20);
    rd(8'h10, 32'hFF, "sp iret");
    rd(8'h00, 32'h11, "acc");
    rd(8'h04, 32'h22, "idx1");
    rd(8'h08, 32'h44, "idx2");
    rd(8'h0C, 32'h1234, "pc");
    $display("done irq");
  endtask
  task automatic t_pend();
    ctl(8'h80);
    apb(1'b1, 8'h1C, 32'h1);
    irq_req <= 4'h3;
    @(posedge clk_sys);
    irq_req <= 4'h0;
    @(posedge clk_sys);
    chk("pend", 32'h1, {31'h0, irq_pending});
    apb(1'b0, 8'h18, 32'h0);
    chk("stat", 32'h1, {28'h0, r[7:4]});
    ctl(8'h00);
    rd(8'h10, 32'hFA, "sp serve");
    chk("pend clr", 32'h0, {31'h0, irq_pending});
    $display("done pend");
  endtask
  task automatic t_reset();
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rd(8'h10, 32'hFF, "sp rst");
    rd(8'h00, 32'h0, "acc rst");
    rd(8'h14, 32'h80, "ctrl rst");
    $display("done reset");
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    t_regs();
    t_stack();
    t_irq();
    t_pend();
    t_reset();
    results();
  end
  initial begin
    #200000;
    mismatches++;
    results();
  end
endmodule // test_cpu_register_stack_control
